// file: verilog/dccs_pkg.sv
// Constants and types for the DMA cache-coherent sequencer
package dccs_pkg;
  // DMA command codes on the three-bit command lines
  localparam logic [2:0] DCCS_CMD_IDLE       = 3'h0;
  localparam logic [2:0] DCCS_CMD_READ       = 3'h1;
  localparam logic [2:0] DCCS_CMD_READ_WRAP  = 3'h2;
  localparam logic [2:0] DCCS_CMD_READ_BURST = 3'h3;
  localparam logic [2:0] DCCS_CMD_READ_WB    = 3'h4;
  localparam logic [2:0] DCCS_CMD_WRITE      = 3'h5;
  // Acknowledge codes, one cycle each
  localparam logic [1:0] DCCS_ACK_IDLE = 2'h0;
  localparam logic [1:0] DCCS_ACK_OK   = 2'h1;
  localparam logic [1:0] DCCS_ACK_ERR  = 2'h2;
  // Address field: line address bits 33 down to 5
  localparam int DCCS_ADR_HI  = 33;
  localparam int DCCS_ADR_LO  = 5;
  localparam int DCCS_ADR_W   = DCCS_ADR_HI - DCCS_ADR_LO + 1;
  // Space decode bit positions within the line address field
  localparam int DCCS_IO_BIT  = 33 - DCCS_ADR_LO;
  localparam int DCCS_NC_BIT  = 32 - DCCS_ADR_LO;
  localparam int DCCS_LSEL_W  = 2;
  // Index of the last octaword in a cache line (two octawords per line)
  localparam logic DCCS_LAST_OCTA = 1'h1;
  // Reset values
  localparam logic [1:0] DCCS_LSEL_RST = 2'h0;
  localparam logic       DCCS_BIT_RST  = 1'h0;

  typedef enum logic [3:0] {
    DCCS_S_IDLE,
    DCCS_S_DEC,
    DCCS_S_RD_HIT2,
    DCCS_S_RD_MISS,
    DCCS_S_WR_INV,
    DCCS_S_WR_TWE,
    DCCS_S_WR_ACK,
    DCCS_S_WR_STALL,
    DCCS_S_ACK_OK,
    DCCS_S_ACK_ERR
  } dccs_state_t;
endpackage

// file: verilog/dccs_sequencer.sv
// DMA-side transaction sequencer of the cache and memory controller
`timescale 1ns/1ps
module dccs_sequencer
  import dccs_pkg::*;
(
  // Clock and reset
  input  wire logic                   mclk,
  input  wire logic                   reset,
  // DMA master pins
  input  wire logic                   dma_bus_grant,
  input  wire logic [2:0]             dma_command_code,
  input  wire logic [DCCS_ADR_W-1:0]  shared_line_address,
  input  wire logic [DCCS_LSEL_W-1:0] buffer_line_selector,
  output logic                        dma_read_data_ready,
  output logic [1:0]                  dma_transaction_acknowledge,
  output logic                        next_line_hint,
  output logic [DCCS_LSEL_W-1:0]      buffer_line_target,
  // Controller-internal status
  input  wire logic                   cache_enable_setting,
  input  wire logic                   probe_tag_hit,
  input  wire logic                   memory_octaword_valid,
  input  wire logic                   write_buffer_full,
  input  wire logic                   release_permitted,
  input  wire logic                   preemption_active,
  // Cache and processor controls
  output logic                        processor_hold_request,
  output logic                        processor_write_data_select,
  output logic                        processor_dcache_invalidate_request,
  output logic                        early_output_enable_control,
  output logic                        cache_tag_output_enable,
  output logic                        cache_data_output_enable,
  output logic                        cache_tag_write_enable,
  output logic                        tag_invalid_drive_enable,
  output logic                        cache_octaword_address,
  // Data path controls
  output logic                        datapath_octaword_select,
  output logic                        read_buffer_load,
  output logic                        write_buffer_transfer,
  output logic                        system_data_drive_enable
);
  localparam int SYNC_W = 1 + 3 + DCCS_ADR_W + DCCS_LSEL_W;
  // Pin synchroniser; only the second stage is read
  logic [SYNC_W-1:0] sync1_r, sync2_r;
  logic              grant_s;
  logic [2:0]        cmd_s;
  logic [DCCS_ADR_W-1:0] adr_s;
  logic [DCCS_LSEL_W-1:0] lsel_s;
  always_ff @(posedge mclk) begin
    if (reset) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {dma_bus_grant, dma_command_code, shared_line_address, buffer_line_selector};
      sync2_r <= sync1_r;
    end
  end
  assign {grant_s, cmd_s, adr_s, lsel_s} = sync2_r;
  // Sequencer state
  dccs_state_t state_r, state_nxt;
  logic        is_write_r, is_write_nxt;
  logic        wrap_r, wrap_nxt;
  logic        burst_r, burst_nxt;
  logic        io_r, io_nxt;
  logic        cach_r, cach_nxt;
  logic        hit_r, hit_nxt;
  logic        cnt_r, cnt_nxt;
  logic        released_r, released_nxt;
  logic        bit4_r, bit4_nxt;
  logic        dpsel_r, dpsel_nxt;
  logic [DCCS_LSEL_W-1:0] line_r, line_nxt;
  logic        cmd_valid, cmd_read, probe_hit;
  assign cmd_read  = (cmd_s == DCCS_CMD_READ) || (cmd_s == DCCS_CMD_READ_WRAP) ||
                     (cmd_s == DCCS_CMD_READ_BURST) || (cmd_s == DCCS_CMD_READ_WB);
  assign cmd_valid = cmd_read || (cmd_s == DCCS_CMD_WRITE);
  // Probe counts only for enabled cacheable space
  assign probe_hit = probe_tag_hit && cach_r && cache_enable_setting;
  always_comb begin
    state_nxt    = state_r;
    is_write_nxt = is_write_r;
    wrap_nxt     = wrap_r;
    burst_nxt    = burst_r;
    io_nxt       = io_r;
    cach_nxt     = cach_r;
    hit_nxt      = hit_r;
    cnt_nxt      = cnt_r;
    released_nxt = released_r;
    bit4_nxt     = bit4_r;
    dpsel_nxt    = dpsel_r;
    line_nxt     = line_r;
    dma_read_data_ready                 = 1'b0;
    dma_transaction_acknowledge         = DCCS_ACK_IDLE;
    processor_dcache_invalidate_request = 1'b0;
    cache_tag_write_enable              = 1'b0;
    tag_invalid_drive_enable            = 1'b0;
    read_buffer_load                    = 1'b0;
    write_buffer_transfer               = 1'b0;
    system_data_drive_enable            = 1'b0;
    case (state_r)
      DCCS_S_IDLE: begin
        bit4_nxt     = 1'b0;
        if (grant_s && cmd_valid) begin
          state_nxt    = DCCS_S_DEC;
          is_write_nxt = !cmd_read;
          wrap_nxt     = (cmd_s == DCCS_CMD_READ_WRAP) || (cmd_s == DCCS_CMD_READ_WB);
          burst_nxt    = (cmd_s == DCCS_CMD_READ_BURST) || (cmd_s == DCCS_CMD_READ_WB);
          io_nxt       = adr_s[DCCS_IO_BIT];
          cach_nxt     = !adr_s[DCCS_NC_BIT];
          line_nxt     = lsel_s;
          cnt_nxt      = 1'b0;
          dpsel_nxt    = (cmd_s == DCCS_CMD_READ_WRAP) || (cmd_s == DCCS_CMD_READ_WB);
        end
      end
      DCCS_S_DEC: begin
        hit_nxt = probe_hit;
        if (io_r) begin
          system_data_drive_enable = 1'b1;
          state_nxt = DCCS_S_ACK_ERR;
        end else if (!is_write_r) begin
          if (probe_hit) begin
            read_buffer_load = 1'b1;
            bit4_nxt  = 1'b1;
            dpsel_nxt = 1'b0;
            cnt_nxt   = DCCS_LAST_OCTA;
            state_nxt = DCCS_S_RD_HIT2;
          end else begin
            state_nxt = DCCS_S_RD_MISS;
          end
        end else begin
          processor_dcache_invalidate_request = !cache_enable_setting;
          if (write_buffer_full) begin
            state_nxt = DCCS_S_WR_STALL;
          end else begin
            write_buffer_transfer = 1'b1;
            state_nxt = probe_hit ? DCCS_S_WR_INV : DCCS_S_ACK_OK;
          end
        end
      end
      DCCS_S_RD_HIT2: begin
        read_buffer_load            = 1'b1;
        dma_read_data_ready         = 1'b1;
        dma_transaction_acknowledge = DCCS_ACK_OK;
        state_nxt                   = DCCS_S_IDLE;
      end
      DCCS_S_RD_MISS: begin
        if (!released_r && !cnt_r && release_permitted && !preemption_active)
          released_nxt = 1'b1;
        if (memory_octaword_valid) begin
          read_buffer_load    = 1'b1;
          dma_read_data_ready = 1'b1;
          cnt_nxt             = DCCS_LAST_OCTA;
          dpsel_nxt           = 1'b0;
          if (cnt_r == DCCS_LAST_OCTA) begin
            released_nxt = 1'b0;
            dma_transaction_acknowledge = DCCS_ACK_OK;
            state_nxt = DCCS_S_IDLE;
          end
        end
      end
      DCCS_S_WR_STALL: begin
        // Release only when the probe missed
        if (!hit_r && release_permitted && !preemption_active)
          released_nxt = 1'b1;
        if (!write_buffer_full) begin
          released_nxt          = 1'b0;
          write_buffer_transfer = 1'b1;
          state_nxt = hit_r ? DCCS_S_WR_INV : DCCS_S_ACK_OK;
        end
      end
      DCCS_S_WR_INV: begin
        tag_invalid_drive_enable = 1'b1;
        write_buffer_transfer    = 1'b1;
        state_nxt                = DCCS_S_WR_TWE;
      end
      DCCS_S_WR_TWE: begin
        // Data array untouched; long-write setting has no say here
        tag_invalid_drive_enable = 1'b1;
        cache_tag_write_enable   = 1'b1;
        state_nxt                = DCCS_S_WR_ACK;
      end
      DCCS_S_WR_ACK: begin
        dma_transaction_acknowledge = DCCS_ACK_OK;
        state_nxt                   = DCCS_S_IDLE;
      end
      DCCS_S_ACK_OK: begin
        write_buffer_transfer       = 1'b1;
        dma_transaction_acknowledge = DCCS_ACK_OK;
        state_nxt                   = DCCS_S_IDLE;
      end
      DCCS_S_ACK_ERR: begin
        dma_transaction_acknowledge = DCCS_ACK_ERR;
        state_nxt                   = DCCS_S_IDLE;
      end
      default: state_nxt = DCCS_S_IDLE;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (reset) begin
      state_r    <= DCCS_S_IDLE;
      is_write_r <= DCCS_BIT_RST;
      wrap_r     <= DCCS_BIT_RST;
      burst_r    <= DCCS_BIT_RST;
      io_r       <= DCCS_BIT_RST;
      cach_r     <= DCCS_BIT_RST;
      hit_r      <= DCCS_BIT_RST;
      cnt_r      <= DCCS_BIT_RST;
      released_r <= DCCS_BIT_RST;
      bit4_r     <= DCCS_BIT_RST;
      dpsel_r    <= DCCS_BIT_RST;
      line_r     <= DCCS_LSEL_RST;
    end else begin
      state_r    <= state_nxt;
      is_write_r <= is_write_nxt;
      wrap_r     <= wrap_nxt;
      burst_r    <= burst_nxt;
      io_r       <= io_nxt;
      cach_r     <= cach_nxt;
      hit_r      <= hit_nxt;
      cnt_r      <= cnt_nxt;
      released_r <= released_nxt;
      bit4_r     <= bit4_nxt;
      dpsel_r    <= dpsel_nxt;
      line_r     <= line_nxt;
    end
  end
  // Cache and processor steering while DMA owns the bus
  logic dma_owns, wr_inval;
  assign dma_owns = grant_s || (state_r != DCCS_S_IDLE);
  assign wr_inval = (state_r == DCCS_S_WR_INV) || (state_r == DCCS_S_WR_TWE) ||
                    (state_r == DCCS_S_WR_ACK) ||
                    ((state_r == DCCS_S_DEC) && is_write_r && probe_hit);
  assign processor_hold_request      = dma_owns && !released_r;
  assign processor_write_data_select = dma_owns && !released_r;
  // Early enable keeps buses from floating while the processor may run
  assign early_output_enable_control = (state_r == DCCS_S_RD_MISS) ||
                                       (state_r == DCCS_S_WR_STALL && released_r);
  assign cache_tag_output_enable     = dma_owns && !released_r && !wr_inval;
  assign cache_data_output_enable    = dma_owns && !released_r;
  assign cache_octaword_address      = bit4_r;
  assign datapath_octaword_select    = dpsel_r;
  assign next_line_hint              = burst_r;
  assign buffer_line_target          = line_r;
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  sequence s_rd_hit_dec;
    state_r == DCCS_S_DEC && !io_r && !is_write_r && probe_hit;
  endsequence
  sequence s_wr_hit_dec;
    state_r == DCCS_S_DEC && !io_r && is_write_r && probe_hit && !write_buffer_full;
  endsequence
  sequence s_invalidate;
    tag_invalid_drive_enable && !cache_tag_write_enable ##1
    cache_tag_write_enable ##1
    !cache_tag_write_enable && dma_transaction_acknowledge == DCCS_ACK_OK;
  endsequence
  property p_rd_hit;
    s_rd_hit_dec |-> read_buffer_load && dma_transaction_acknowledge == DCCS_ACK_IDLE ##1
      cache_octaword_address && read_buffer_load && dma_read_data_ready &&
      dma_transaction_acknowledge == DCCS_ACK_OK;
  endproperty
  a_rd_hit: assert property (p_rd_hit) else $error("read hit timing wrong");
  property p_io_err;
    state_r == DCCS_S_DEC && io_r |-> system_data_drive_enable && !read_buffer_load ##1
      !system_data_drive_enable && dma_transaction_acknowledge == DCCS_ACK_ERR;
  endproperty
  a_io_err: assert property (p_io_err) else $error("io space not errored");
  property p_wr_hit;
    s_wr_hit_dec |-> !cache_tag_output_enable ##1 s_invalidate;
  endproperty
  a_wr_hit: assert property (p_wr_hit) else $error("write hit invalidate wrong");
  property p_isolate;
    grant_s && state_r == DCCS_S_IDLE |->
      processor_write_data_select && !early_output_enable_control &&
      cache_tag_output_enable && cache_data_output_enable;
  endproperty
  a_isolate: assert property (p_isolate) else $error("bus not prepared for DMA");
  property p_wr_miss;
    state_r == DCCS_S_DEC && !io_r && is_write_r && !probe_hit && !write_buffer_full |->
      write_buffer_transfer && dma_transaction_acknowledge == DCCS_ACK_IDLE ##1
      dma_transaction_acknowledge == DCCS_ACK_OK;
  endproperty
  a_wr_miss: assert property (p_wr_miss) else $error("write miss ack wrong");
  property p_ack_one;
    dma_transaction_acknowledge != DCCS_ACK_IDLE |=>
      dma_transaction_acknowledge == DCCS_ACK_IDLE;
  endproperty
  a_ack_one: assert property (p_ack_one) else $error("ack longer than one cycle");
  property p_miss_early;
    state_r == DCCS_S_RD_MISS |-> early_output_enable_control;
  endproperty
  a_miss_early: assert property (p_miss_early) else $error("early enable low");
  property p_wrap;
    state_r == DCCS_S_DEC && !io_r && !is_write_r && wrap_r |->
      datapath_octaword_select;
  endproperty
  a_wrap: assert property (p_wrap) else $error("wrapped order wrong");
  property p_full;
    state_r == DCCS_S_DEC && !io_r && is_write_r && write_buffer_full |->
      !write_buffer_transfer ##1 dma_transaction_acknowledge == DCCS_ACK_IDLE;
  endproperty
  a_full: assert property (p_full) else $error("full buffer transferred");
  property p_dinv;
    state_r == DCCS_S_DEC && !io_r && is_write_r && !cache_enable_setting |->
      processor_dcache_invalidate_request ##1 state_r != DCCS_S_WR_INV;
  endproperty
  a_dinv: assert property (p_dinv) else $error("disabled cache not missed");
  property p_miss_ack;
    state_r == DCCS_S_RD_MISS && memory_octaword_valid |-> dma_read_data_ready &&
      read_buffer_load && (dma_transaction_acknowledge == DCCS_ACK_OK) == cnt_r;
  endproperty
  a_miss_ack: assert property (p_miss_ack) else $error("miss ack without data");
endmodule

// file: testbench/dccs_dma_master.sv
// DMA master model driving grant, command, address and line selector
`timescale 1ns/1ps
module dccs_dma_master
  import dccs_pkg::*;
(
  // Clock
  input  wire logic              mclk,
  // Bus pins toward the sequencer
  output logic                   dma_bus_grant,
  output logic [2:0]             dma_command_code,
  output logic [DCCS_ADR_W-1:0]  shared_line_address,
  output logic [DCCS_LSEL_W-1:0] buffer_line_selector
);
  initial begin
    dma_bus_grant = 1'h1;
    dma_command_code = DCCS_CMD_IDLE;
    shared_line_address = '0;
    buffer_line_selector = 2'h0;
  end
  // One command cycle only, so an idle sequencer never retakes it
  task automatic issue(input logic [2:0] cmd, input logic [DCCS_ADR_W-1:0] adr);
    @(posedge mclk);
    #1;
    dma_command_code = cmd;
    shared_line_address = adr;
    buffer_line_selector = 2'h2;
    @(posedge mclk);
    #1;
    dma_command_code = DCCS_CMD_IDLE;
    // Released lines change rather than hold their value
    shared_line_address = ~adr;
    buffer_line_selector = 2'h1;
  endtask
endmodule

// file: testbench/test_dccs_sequencer.sv
// Testbench for the DMA cache-coherent sequencer
`timescale 1ns/1ps
module test_dccs_sequencer;
  import dccs_pkg::*;
  // Decode cycle as counted from the end of the command cycle
  localparam int C_DEC = 3;
  localparam logic [DCCS_ADR_W-1:0] A_MEM = 29'h00012340;
  localparam logic [DCCS_ADR_W-1:0] A_IO  = 29'h10012340;
  localparam logic [DCCS_ADR_W-1:0] A_NC  = 29'h08012340;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic cache_enable_setting = 1'h1;
  logic probe_tag_hit = 1'h0;
  logic memory_octaword_valid = 1'h0;
  logic write_buffer_full = 1'h0;
  logic release_permitted = 1'h0;
  logic preemption_active = 1'h0;
  logic dma_bus_grant, dma_read_data_ready, next_line_hint, processor_hold_request;
  logic processor_write_data_select, processor_dcache_invalidate_request;
  logic early_output_enable_control, cache_tag_output_enable, cache_data_output_enable;
  logic cache_tag_write_enable, tag_invalid_drive_enable, cache_octaword_address;
  logic datapath_octaword_select, read_buffer_load, write_buffer_transfer;
  logic system_data_drive_enable;
  logic [2:0] dma_command_code;
  logic [DCCS_ADR_W-1:0] shared_line_address;
  logic [1:0] buffer_line_selector, buffer_line_target, dma_transaction_acknowledge, ack_v;
  int n_mismatch = 0;
  int n_tests = 0;
  int ack_c, n_rdy, n_load, n_xfer, n_twe, twe_c, n_tid, n_dinv, n_sdd, sdd_c;
  logic sel1, sel2, oa_ack, rdy_ack, hint, early, hold_drop, toe_low, xfer_dec;

  always #10 mclk = ~mclk;

  dccs_dma_master u_master (.mclk, .dma_bus_grant, .dma_command_code, .shared_line_address,
                            .buffer_line_selector);
  dccs_sequencer u_dut (.mclk, .reset, .dma_bus_grant, .dma_command_code,
    .shared_line_address, .buffer_line_selector, .dma_read_data_ready,
    .dma_transaction_acknowledge, .next_line_hint, .buffer_line_target,
    .cache_enable_setting, .probe_tag_hit, .memory_octaword_valid, .write_buffer_full,
    .release_permitted, .preemption_active, .processor_hold_request,
    .processor_write_data_select, .processor_dcache_invalidate_request,
    .early_output_enable_control, .cache_tag_output_enable, .cache_data_output_enable,
    .cache_tag_write_enable, .tag_invalid_drive_enable, .cache_octaword_address,
    .datapath_octaword_select, .read_buffer_load, .write_buffer_transfer,
    .system_data_drive_enable);

  task automatic complete_run();
    $display("Counts: %0d compares, %0d mismatches", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s seen %0h expected %0h", $time, msg, seen, exp);
    end
  endtask

  // Issue one command and log the answer cycle by cycle until acknowledge
  task automatic run(input logic [2:0] cmd, input logic [DCCS_ADR_W-1:0] adr,
                     input int mc, input int fc);
    {ack_c, n_rdy, n_load, n_xfer, n_twe, twe_c, n_tid, n_dinv, n_sdd, sdd_c} = '0;
    {sel1, sel2, oa_ack, rdy_ack, early, hold_drop, toe_low, xfer_dec} = '0;
    u_master.issue(cmd, adr);
    for (int c = 1; c < 40 && ack_c == 0; c++) begin
      memory_octaword_valid = (mc != 0) && (c == mc || c == mc + 2);
      if (c == fc) write_buffer_full = 1'h0;
      @(negedge mclk);
      if (read_buffer_load === 1'h1) begin
        if (n_load == 0) sel1 = datapath_octaword_select;
        else sel2 = datapath_octaword_select;
        n_load++;
      end
      if (c == C_DEC) xfer_dec = write_buffer_transfer;
      if (write_buffer_transfer === 1'h1) n_xfer++;
      if (dma_read_data_ready === 1'h1) n_rdy++;
      if (tag_invalid_drive_enable === 1'h1) n_tid++;
      if (processor_dcache_invalidate_request === 1'h1) n_dinv++;
      if (cache_tag_write_enable === 1'h1) begin
        n_twe++;
        twe_c = c;
      end
      if (system_data_drive_enable === 1'h1) begin
        n_sdd++;
        sdd_c = c;
      end
      early |= early_output_enable_control === 1'h1;
      hold_drop |= processor_hold_request === 1'h0;
      toe_low |= cache_tag_output_enable === 1'h0;
      if (dma_transaction_acknowledge !== DCCS_ACK_IDLE) begin
        ack_c = c;
        ack_v = dma_transaction_acknowledge;
        oa_ack = cache_octaword_address;
        rdy_ack = dma_read_data_ready;
        hint = next_line_hint;
      end
      @(posedge mclk);
      #1;
    end
    memory_octaword_valid = 1'h0;
    if (ack_c == 0) begin
      n_mismatch++;
      $display("[FAIL] %0t no acknowledge", $time);
      complete_run();
    end
  endtask

  task automatic t_idle();
    chk(processor_write_data_select, 1, "write select");
    chk(early_output_enable_control, 0, "early enable");
    chk(cache_tag_output_enable, 1, "tag enable");
    chk(cache_data_output_enable, 1, "data enable");
    chk(dma_transaction_acknowledge, DCCS_ACK_IDLE, "idle ack");
    $display("Test idle done");
  endtask

  // All four read commands back to back, each hitting
  task automatic t_read_hit();
    probe_tag_hit = 1'h1;
    for (logic [2:0] cmd = DCCS_CMD_READ; cmd <= DCCS_CMD_READ_WB; cmd++) begin
      run(cmd, A_MEM, 0, 0);
      chk(ack_c, C_DEC + 1, "hit ack cycle");
      chk(ack_v, DCCS_ACK_OK, "hit ack code");
      chk(rdy_ack, 1, "ready with ack");
      chk(n_load, 2, "hit loads");
      chk(oa_ack, 1, "octaword address bit 4");
      chk(sel1, cmd == DCCS_CMD_READ_WRAP || cmd == DCCS_CMD_READ_WB, "first select");
      chk(sel2, 0, "second select");
      chk(hint, cmd >= DCCS_CMD_READ_BURST, "next line hint");
      chk(buffer_line_target, 2'h2, "line target");
    end
    $display("Test read hit done");
  endtask

  task automatic t_read_miss();
    probe_tag_hit = 1'h0;
    release_permitted = 1'h1;
    run(DCCS_CMD_READ, A_MEM, C_DEC + 2, 0);
    chk(ack_c, C_DEC + 4, "miss ack cycle");
    chk(rdy_ack, 1, "ready with ack");
    chk(n_rdy, 2, "ready per octaword");
    chk(early, 1, "early enable in wait");
    chk(hold_drop, 1, "released");
    preemption_active = 1'h1;
    run(DCCS_CMD_READ, A_MEM, C_DEC + 2, 0);
    chk(hold_drop, 0, "no release in preemption");
    preemption_active = 1'h0;
    release_permitted = 1'h0;
    probe_tag_hit = 1'h1;
    run(DCCS_CMD_READ, A_NC, C_DEC + 2, 0);
    chk(ack_c, C_DEC + 4, "noncacheable ack");
    chk(n_load, 2, "noncacheable loads");
    $display("Test read miss done");
  endtask

  task automatic t_io();
    for (int i = 0; i < 2; i++) begin
      run(i == 0 ? DCCS_CMD_READ : DCCS_CMD_WRITE, A_IO, 0, 0);
      chk(ack_c, C_DEC + 1, "error ack cycle");
      chk(ack_v, DCCS_ACK_ERR, "error code");
      chk(n_load + n_xfer, 0, "no data moved");
      if (i == 0) chk(sdd_c * 8 + n_sdd, C_DEC * 8 + 1, "bus drive");
    end
    $display("Test io done");
  endtask

  task automatic t_write();
    probe_tag_hit = 1'h1;
    run(DCCS_CMD_WRITE, A_MEM, 0, 0);
    chk(ack_c, C_DEC + 3, "write hit ack");
    chk(twe_c * 8 + n_twe, (C_DEC + 2) * 8 + 1, "tag write");
    chk(n_tid, 2, "invalid tags");
    chk(toe_low, 1, "tag enable off");
    chk(n_xfer * 8 + n_load, 16, "no cache data");
    run(DCCS_CMD_WRITE, A_NC, 0, 0);
    chk(ack_c * 8 + n_twe, (C_DEC + 1) * 8, "noncacheable write");
    cache_enable_setting = 1'h0;
    run(DCCS_CMD_WRITE, A_MEM, 0, 0);
    chk(ack_c * 8 + n_twe, (C_DEC + 1) * 8, "disabled is miss");
    chk(n_dinv, 1, "dcache invalidate");
    cache_enable_setting = 1'h1;
    probe_tag_hit = 1'h0;
    run(DCCS_CMD_WRITE, A_MEM, 0, 0);
    chk(ack_c, C_DEC + 1, "miss ack");
    chk(xfer_dec * 8 + n_xfer, 10, "miss transfers");
    write_buffer_full = 1'h1;
    release_permitted = 1'h1;
    run(DCCS_CMD_WRITE, A_MEM, 0, 7);
    release_permitted = 1'h0;
    chk(xfer_dec * 8 + n_xfer, 2, "stall transfers");
    chk(ack_c, 8, "resume ack");
    chk(hold_drop, 1, "stall released");
    chk(early, 1, "early enable in stall");
    $display("Test write done");
  endtask

  initial begin
    repeat (10) @(posedge mclk);
    #1;
    reset = 1'h0;
    repeat (4) @(posedge mclk);
    #1;
    t_idle();
    t_read_hit();
    t_read_miss();
    t_io();
    t_write();
    complete_run();
  end
endmodule
